//--- hw/sbs_burst_counter.sv
// Two-bit wrap-around burst counter with linear or interleaved order.
// Assumes load and step are already qualified by the caller.
`default_nettype none

module sbs_burst_counter (
   // Clock and reset
   input  wire logic                        clock,
   input  wire logic                        reset_n,
   // Control
   input  wire logic                        load,
   input  wire logic                        step,
   input  wire logic                        interleaved,
   input  wire logic [sbs_pkg::BURST_W-1:0] startBits,
   // Count
   output logic      [sbs_pkg::BURST_W-1:0] countNow,
   output logic      [sbs_pkg::BURST_W-1:0] countStep
);
   logic [sbs_pkg::BURST_W-1:0] start;
   logic [sbs_pkg::BURST_W-1:0] seq;
   logic [sbs_pkg::BURST_W-1:0] seqNext;

   // ==========================================================
   // Order selection, start plus count or start XOR count
   // Sums wrap inside two bits: the carry is dropped on purpose
   assign seqNext   = sbs_pkg::BURST_W'(seq + sbs_pkg::BURST_ONE);
   assign countNow  = interleaved ? (start ^ seq)
                                  : sbs_pkg::BURST_W'(start + seq); // [R18]
   assign countStep = interleaved ? (start ^ seqNext)
                                  : sbs_pkg::BURST_W'(start + seqNext); // [R10] [R18]

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         start <= sbs_pkg::BURST_RST;
         seq   <= sbs_pkg::BURST_RST;
      end else if (load) begin
         start <= startBits; // [R15]
         seq   <= sbs_pkg::BURST_RST;
      end else if (step) begin
         seq   <= seqNext; // [R02]
      end
   end

   // ==========================================================
   // Checks
   property p_step_adv;
      @(posedge clock) disable iff (!reset_n)
      (step && !load) |=> (countNow == $past(countStep));
   endproperty
   a_step_adv: assert property (p_step_adv) // [R02]
      else $error("burst counter did not advance");

   property p_load_start;
      @(posedge clock) disable iff (!reset_n)
      load |=> (seq == sbs_pkg::BURST_RST) && (start == $past(startBits));
   endproperty
   a_load_start: assert property (p_load_start) // [R15]
      else $error("burst counter did not load start bits");
endmodule // sbs_burst_counter

`default_nettype wire

//--- hw/sbs_pkg.sv
// Constants for the synchronous burst SRAM pin control block.
// Assumes one 50 MHz clock and pins already synchronous to it.
//
// What this block does
// [R01] Active-low lane selects, gated by byte-write gate
// [R02] Burst step low advances the burst counter
// [R03] Host drives byte-write gate low for lanes
// [R04] All-byte write overrides gate and lane selects
// [R05] Synchronous inputs sampled on rising clock only
// [R06] Selected when one low, two high, three low
// [R07] Chip select one gates the processor strobe
// [R08] Output drive low drives pins, high releases
// [R09] Sleep request ignores inputs, keeps array contents
// [R10] Burst order high interleaved, low linear
// [R11] Data lines captured on the rising edge
// [R12] Read data appears one registered cycle later
// [R13] Detected write always three-states data outputs
// [R14] Parity lines behave exactly like data lines
// [R15] Strobe loads address; processor strobe wins ties
// [R16] Processor-strobe start cycle is always a read
// [R17] Host waits two cycles around sleep changes
// [R18] Linear adds one; interleaved XORs a count
`default_nettype none

package sbs_pkg;
   // ==========================================================
   // Geometry
   localparam int ADDR_W   = 17;
   localparam int DATA_W   = 16;
   localparam int PAR_W    = 2;
   localparam int LANES    = 2;
   localparam int LANE_W   = 9;
   localparam int WORD_W   = LANES * LANE_W;
   localparam int DEPTH    = 131072;
   localparam int BURST_W  = 2;
   // ==========================================================
   // Reset values
   localparam logic [DATA_W-1:0]  DATA_RST  = 16'h0000;
   localparam logic [PAR_W-1:0]   PAR_RST   = 2'h0;
   localparam logic [ADDR_W-1:0]  ADDR_RST  = 17'h00000;
   localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
   localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
   // ==========================================================
   // Host settling time around a sleep change
   localparam int CLK_PERIOD_NS  = 20;
   localparam int SLEEP_SETTLE_NS = 2 * CLK_PERIOD_NS;
   localparam int SLEEP_SETTLE_CYC =
      (SLEEP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : sbs_pkg

`default_nettype wire

//--- hw/sbs_sram_pin_ctrl.sv
// Pin-level control of a 128K x 18 synchronous burst SRAM core.
// Assumes all pins, including output drive and sleep, are synchronous
// to clock; the three-state wire is resolved outside from the enables.
`default_nettype none

module sbs_sram_pin_ctrl (
   // Clock and reset
   input  wire logic                       clock,
   input  wire logic                       reset_n,
   // Address and strobes
   input  wire logic [sbs_pkg::ADDR_W-1:0] addr,
   input  wire logic                       cpu_addr_strobe_n,
   input  wire logic                       ctrl_addr_strobe_n,
   input  wire logic                       burst_step_n,
   input  wire logic                       burst_order,
   // Chip selects
   input  wire logic                       chip_sel_one_n,
   input  wire logic                       chip_sel_two,
   input  wire logic                       chip_sel_three_n,
   // Write controls
   input  wire logic                       all_byte_write_n,
   input  wire logic                       byte_write_gate_n,
   input  wire logic [sbs_pkg::LANES-1:0]  byte_lane_select_n,
   // Output drive and sleep
   input  wire logic                       out_drive_n,
   input  wire logic                       sleep_req,
   // Data pins
   input  wire logic [sbs_pkg::DATA_W-1:0] dataIn,
   output logic      [sbs_pkg::DATA_W-1:0] dataOut,
   output logic                            dataOe,
   // Parity pins
   input  wire logic [sbs_pkg::PAR_W-1:0]  parityIn,
   output logic      [sbs_pkg::PAR_W-1:0]  parityOut,
   output logic                            parityOe,
   // Status
   output logic                            standby,
   output logic                            burstActive
);
   // Array has no reset: contents survive reset and sleep alike
   logic [sbs_pkg::WORD_W-1:0]  mem [0:sbs_pkg::DEPTH-1];
   logic [sbs_pkg::ADDR_W-1:0]  regAddr;
   logic [sbs_pkg::BURST_W-1:0] countNow;
   logic [sbs_pkg::BURST_W-1:0] countStep;
   logic                        next_dataOe;
   logic [sbs_pkg::WORD_W-1:0]  next_word;

   wire                         selected;
   wire                         cpuSeen;
   wire                         ctrlSeen;
   wire                         strobeSeen;
   wire                         startNow;
   wire                         cpuStart;
   wire                         ctrlStart;
   wire                         contNow;
   wire                         stepNow;
   wire                         writeReq;
   wire                         writeNow;
   wire                         readNow;
   wire [sbs_pkg::LANES-1:0]    laneWrite;
   wire [sbs_pkg::ADDR_W-1:0]   curAddr;
   wire [sbs_pkg::WORD_W-1:0]   oldWord;
   wire [sbs_pkg::WORD_W-1:0]   pinWord;

   // ==========================================================
   // Selection and strobes, all sampled at the rising edge
   assign selected   = !chip_sel_one_n && chip_sel_two
                       && !chip_sel_three_n; // [R06] [R05]
   assign cpuSeen    = !cpu_addr_strobe_n && !chip_sel_one_n; // [R07]
   assign ctrlSeen   = !ctrl_addr_strobe_n && !cpuSeen; // [R15]
   assign strobeSeen = (cpuSeen || ctrlSeen) && !sleep_req; // [R09]
   assign startNow   = strobeSeen && selected; // [R06]
   assign cpuStart   = startNow && cpuSeen;
   assign ctrlStart  = startNow && ctrlSeen;
   assign contNow    = burstActive && !strobeSeen && !sleep_req;
   assign stepNow    = contNow && !burst_step_n; // [R02]

   // ==========================================================
   // Write qualification
   assign laneWrite = !all_byte_write_n ? {sbs_pkg::LANES{1'b1}} // [R04]
                    : (!byte_write_gate_n ? ~byte_lane_select_n // [R01]
                                          : {sbs_pkg::LANES{1'b0}}); // [R03]
   assign writeReq  = |laneWrite;
   // A processor-strobe start never writes; later clocks may
   assign writeNow  = (ctrlStart || contNow) && writeReq; // [R16]
   assign readNow   = (startNow || contNow) && !writeNow;

   // ==========================================================
   // Address path: a start uses the pins, else register plus burst
   assign curAddr = startNow ? addr
                  : {regAddr[sbs_pkg::ADDR_W-1:sbs_pkg::BURST_W],
                     stepNow ? countStep : countNow}; // [R15] [R02]
   assign oldWord = mem[curAddr];
   assign pinWord = {parityIn[1], dataIn[15:8],
                     parityIn[0], dataIn[7:0]}; // [R14]

   // Lane merge, each lane being eight data bits and its parity bit
   genvar k;
   generate
      for (k = 0; k < sbs_pkg::LANES; k = k + 1) begin : g_lane
         assign next_word[k*sbs_pkg::LANE_W +: sbs_pkg::LANE_W] =
            laneWrite[k] ? pinWord[k*sbs_pkg::LANE_W +: sbs_pkg::LANE_W]
                         : oldWord[k*sbs_pkg::LANE_W +: sbs_pkg::LANE_W];
      end
   endgenerate

   // Write detection forces release; output drive only matters on reads
   assign next_dataOe = readNow && !out_drive_n; // [R08] [R13]

   // ==========================================================
   // Burst counter
   sbs_burst_counter u_counter (
      .clock       (clock),
      .reset_n     (reset_n),
      .load        (startNow),
      .step        (stepNow),
      .interleaved (burst_order),
      .startBits   (addr[sbs_pkg::BURST_W-1:0]),
      .countNow    (countNow),
      .countStep   (countStep)
   );

   // ==========================================================
   // Array write: pins are captured straight into the array
   always_ff @(posedge clock) begin
      if (writeNow) begin
         mem[curAddr] <= next_word; // [R11] [R14]
      end
   end

   // ==========================================================
   // Access state
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         regAddr     <= sbs_pkg::ADDR_RST;
         burstActive <= 1'b0;
         standby     <= 1'b0;
      end else begin
         standby <= sleep_req; // [R09]
         if (startNow) begin
            regAddr     <= addr; // [R15]
            burstActive <= 1'b1;
         end else if (strobeSeen) begin
            burstActive <= 1'b0; // [R06]
         end
      end
   end

   // ==========================================================
   // Output registers, one cycle after the addressing edge
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dataOut   <= sbs_pkg::DATA_RST;
         parityOut <= sbs_pkg::PAR_RST;
         dataOe    <= 1'b0;
         parityOe  <= 1'b0;
      end else begin
         if (readNow) begin
            dataOut   <= {oldWord[16:9], oldWord[7:0]}; // [R12]
            parityOut <= {oldWord[17], oldWord[8]}; // [R14]
         end
         dataOe   <= next_dataOe; // [R08] [R13]
         parityOe <= next_dataOe; // [R14]
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   sequence s_read_start;
      readNow && !out_drive_n;
   endsequence

   sequence s_driven;
      dataOe && parityOe;
   endsequence

   property p_read_drive;
      s_read_start |=> s_driven;
   endproperty
   a_read_drive: assert property (p_read_drive) // [R12]
      else $error("read did not drive pins next cycle");

   property p_write_release;
      writeNow |=> !dataOe && !parityOe;
   endproperty
   a_write_release: assert property (p_write_release) // [R13]
      else $error("pins driven after a write");

   property p_drive_off;
      out_drive_n |=> !dataOe;
   endproperty
   a_drive_off: assert property (p_drive_off) // [R08]
      else $error("pins driven with output drive high");

   property p_deselect;
      (strobeSeen && !selected) |=> !burstActive && !dataOe;
   endproperty
   a_deselect: assert property (p_deselect) // [R06]
      else $error("deselect did not end the access");

   // A gated processor strobe must neither start nor end an access
   property p_cs1_gate;
      (!cpu_addr_strobe_n && chip_sel_one_n && ctrl_addr_strobe_n
       && !sleep_req) |=> (burstActive == $past(burstActive));
   endproperty
   a_cs1_gate: assert property (p_cs1_gate) // [R07]
      else $error("processor strobe honoured while deselected");

   property p_cpu_read;
      cpuStart |-> !writeNow;
   endproperty
   a_cpu_read: assert property (p_cpu_read) // [R16]
      else $error("write on a processor-strobe start");

   property p_all_byte;
      (writeNow && !all_byte_write_n) |-> (laneWrite == 2'h3);
   endproperty
   a_all_byte: assert property (p_all_byte) // [R04]
      else $error("all-byte write missed a lane");

   property p_sleep_hold;
      sleep_req |=> standby && !dataOe && !parityOe
                    && (regAddr == $past(regAddr));
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) // [R09]
      else $error("inputs acted on during sleep");

   property p_load_addr;
      startNow |=> burstActive && (regAddr == $past(addr));
   endproperty
   a_load_addr: assert property (p_load_addr) // [R15]
      else $error("strobe did not load the address");
endmodule // sbs_sram_pin_ctrl

`default_nettype wire

//--- sim/sbs_host_pins.sv
// Host side of the shared data and parity pins.
// Assumes the bench raises hostOe only while the device is released.
`default_nettype none
module sbs_host_pins (
   // Clock
   input  wire logic        clock,
   // Host drive
   input  wire logic [15:0] hostData,
   input  wire logic [1:0]  hostPar,
   input  wire logic        hostOe,
   // Device drive
   input  wire logic [15:0] dataOut,
   input  wire logic [1:0]  parityOut,
   input  wire logic        dataOe,
   input  wire logic        parityOe,
   // Resolved pins
   output logic      [15:0] pinData,
   output logic      [1:0]  pinPar
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // No keeper: a released pin must not hold its last level
   logic [15:0] lastData = '0;
   logic [1:0]  lastPar = '0;
   assign pinData = dataOe ? dataOut : hostOe ? hostData : ~lastData;
   assign pinPar = parityOe ? parityOut : hostOe ? hostPar : ~lastPar;
   always @(posedge clock) begin
      lastData <= pinData;
      lastPar  <= pinPar;
   end
endmodule // sbs_host_pins
`default_nettype wire

//--- sim/test_sync_burst_sram_pin_control.sv
// Self-checking bench for the burst SRAM pin control block.
// Assumes the design package and host pin model are compiled first.
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
   $display("Error %0t: got %h want %h", $time, g, e); end end
module test_sync_burst_sram_pin_control;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Host command word: selects, strobes, writes, lanes, drive
   typedef struct packed {
      logic [2:0] cs;
      logic       cpuN, ctlN, stepN, abwN, gateN;
      logic [1:0] laneN;
      logic       odN;
   } sbs_cmd_t;
   localparam sbs_cmd_t IDLE_R = 11'b010_11111_11_0;
   localparam sbs_cmd_t IDLE_Z = 11'b010_11111_11_1;
   localparam sbs_cmd_t READ   = 11'b010_10111_11_0;
   localparam sbs_cmd_t RD_Z   = 11'b010_10111_11_1;
   localparam sbs_cmd_t CPU_RD = 11'b010_01111_11_0;
   localparam sbs_cmd_t STEP   = 11'b010_11011_11_0;
   localparam sbs_cmd_t WR_ALL = 11'b010_10101_11_0;
   localparam sbs_cmd_t WR_LN0 = 11'b010_10110_10_0;
   localparam sbs_cmd_t WR_NOG = 11'b010_10111_00_0;
   localparam sbs_cmd_t WR_OVR = 11'b010_10100_11_0;
   localparam sbs_cmd_t CPU_WR = 11'b010_01101_11_0;
   localparam sbs_cmd_t TIE_WR = 11'b010_00101_11_0;
   localparam sbs_cmd_t CPU_X1 = 11'b110_01111_11_1;
   localparam sbs_cmd_t DESEL  = 11'b000_10111_11_1;
   localparam logic [16:0] A1 = 17'h00100;
   localparam logic [16:0] A2 = 17'h00200;
   localparam logic [16:0] AB = 17'h00300;
   // ==========================================================
   // Stimulus and observed pins
   logic        clock = 1'b0, reset_n = 1'b0, burstOrder = 1'b1;
   logic        sleepReq = 1'b0, hostOe = 1'b0;
   logic [16:0] addr = '0;
   logic [15:0] hostData = '0, pinData, dataOut;
   logic [1:0]  hostPar = '0, pinPar, parityOut;
   logic        dataOe, parityOe, standby, burstActive;
   sbs_cmd_t    cmd = IDLE_Z;
   int          err_total = 0, n_checks = 0, cycles = 0;
   sbs_sram_pin_ctrl u_dut (
      .clock(clock), .reset_n(reset_n), .addr(addr),
      .cpu_addr_strobe_n(cmd.cpuN), .ctrl_addr_strobe_n(cmd.ctlN),
      .burst_step_n(cmd.stepN), .burst_order(burstOrder),
      .chip_sel_one_n(cmd.cs[2]), .chip_sel_two(cmd.cs[1]),
      .chip_sel_three_n(cmd.cs[0]), .all_byte_write_n(cmd.abwN),
      .byte_write_gate_n(cmd.gateN), .byte_lane_select_n(cmd.laneN),
      .out_drive_n(cmd.odN), .sleep_req(sleepReq), .dataIn(pinData),
      .dataOut(dataOut), .dataOe(dataOe), .parityIn(pinPar),
      .parityOut(parityOut), .parityOe(parityOe), .standby(standby),
      .burstActive(burstActive));
   sbs_host_pins u_host (
      .clock(clock), .hostData(hostData), .hostPar(hostPar),
      .hostOe(hostOe), .dataOut(dataOut), .parityOut(parityOut),
      .dataOe(dataOe), .parityOe(parityOe), .pinData(pinData),
      .pinPar(pinPar));
   initial forever #10 clock = ~clock;
   // ==========================================================
   // Bus cycles: each op holds for one clock; results show one op later
   task automatic op(input logic [16:0] a, input sbs_cmd_t c,
                     input logic [15:0] d, input logic [1:0] p,
                     input logic drv);
      @(posedge clock);
      addr     <= a;
      cmd      <= c;
      hostData <= d;
      hostPar  <= p;
      hostOe   <= drv;
      #1;
   endtask
   // Drive released first, so host data never fights a read
   task automatic wr(input logic [16:0] a, input sbs_cmd_t c,
                     input logic [15:0] d, input logic [1:0] p);
      op(a, IDLE_Z, 16'h0, 2'h0, 1'b0);
      op(a, c, d, p, 1'b1);
      op(a, IDLE_Z, 16'h0, 2'h0, 1'b0);
   endtask
   task automatic rd(input logic [16:0] a, input logic [15:0] d,
                     input logic [1:0] p);
      op(a, READ, 16'h0, 2'h0, 1'b0);
      op(a, IDLE_R, 16'h0, 2'h0, 1'b0);
      `CHK(dataOut, d);
      `CHK(parityOut, p);
      `CHK(dataOe, 1'b1);
      `CHK(parityOe, 1'b1);
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_lanes();
      wr(A2, WR_ALL, 16'h1111, 2'h0);
      wr(A2, WR_LN0, 16'hbbcc, 2'h3);
      wr(A2, WR_NOG, 16'hffff, 2'h3);
      rd(A2, 16'h11cc, 2'h1);
      wr(A2, WR_OVR, 16'h2222, 2'h2);
      rd(A2, 16'h2222, 2'h2);
      $display("test lanes done");
   endtask
   task automatic t_strobe();
      sbs_cmd_t c;
      logic [2:0] bad [3] = '{3'b110, 3'b000, 3'b011};
      wr(A1, CPU_WR, 16'h0bad, 2'h1);
      wr(A1, TIE_WR, 16'h0bad, 2'h1);
      foreach (bad[i]) begin
         c = WR_ALL;
         c.cs = bad[i];
         wr(A1, c, 16'h0bad, 2'h1);
      end
      rd(A1, 16'ha55a, 2'h2);
      op(A1, CPU_X1, 16'h0, 2'h0, 1'b0);
      op(A1, IDLE_Z, 16'h0, 2'h0, 1'b0);
      `CHK(burstActive, 1'b1);
      op(A1, DESEL, 16'h0, 2'h0, 1'b0);
      op(A1, IDLE_Z, 16'h0, 2'h0, 1'b0);
      `CHK(burstActive, 1'b0);
      op(A1, CPU_RD, 16'h0, 2'h0, 1'b0);
      op(A1, RD_Z, 16'h0, 2'h0, 1'b0);
      `CHK(burstActive, 1'b1);
      `CHK(dataOut, 16'ha55a);
      op(A1, IDLE_Z, 16'h0, 2'h0, 1'b0);
      `CHK(dataOe, 1'b0);
      `CHK(parityOe, 1'b0);
      $display("test strobes done");
   endtask
   task automatic t_burst();
      logic [1:0] idx;
      for (int i = 0; i < 4; i++)
         wr(AB + 17'(i), WR_ALL, {14'h0400, 2'(i)}, 2'(i));
      for (int o = 0; o < 2; o++) begin
         @(posedge clock);
         burstOrder <= o[0];
         op(AB + 17'h1, READ, 16'h0, 2'h0, 1'b0);
         for (int n = 0; n < 4; n++) begin
            op(AB, (n < 3) ? STEP : IDLE_R, 16'h0, 2'h0, 1'b0);
            idx = o[0] ? (2'h1 ^ 2'(n)) : (2'h1 + 2'(n));
            `CHK(dataOut, {14'h0400, idx});
         end
      end
      $display("test burst done");
   endtask
   task automatic t_sleep();
      op(A1, READ, 16'h0, 2'h0, 1'b0);
      @(posedge clock);
      sleepReq <= 1'b1;
      repeat (sbs_pkg::SLEEP_SETTLE_CYC)
         op(A1, IDLE_R, 16'h0, 2'h0, 1'b0);
      `CHK(standby, 1'b1);
      `CHK(dataOe, 1'b0);
      wr(A1, WR_ALL, 16'hdead, 2'h0);
      @(posedge clock);
      sleepReq <= 1'b0;
      repeat (sbs_pkg::SLEEP_SETTLE_CYC)
         op(A1, IDLE_Z, 16'h0, 2'h0, 1'b0);
      `CHK(standby, 1'b0);
      rd(A1, 16'ha55a, 2'h2);
      $display("test sleep done");
   endtask
   // ==========================================================
   // Main sequence and hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         err_total++;
         close_out();
      end
   end
   initial begin
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      op(A1, IDLE_Z, 16'h0, 2'h0, 1'b0);
      `CHK(dataOe, 1'b0);
      `CHK(burstActive, 1'b0);
      $display("test reset done");
      wr(A1, WR_ALL, 16'ha55a, 2'h2);
      `CHK(dataOe, 1'b0);
      `CHK(parityOe, 1'b0);
      rd(A1, 16'ha55a, 2'h2);
      $display("test write_read done");
      t_lanes();
      t_strobe();
      t_burst();
      t_sleep();
      close_out();
   end
endmodule // test_sync_burst_sram_pin_control
`default_nettype wire
